// [logic/nfc_top.sv]
// Network feature negotiation and configuration register bank
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module nfc_top #(
  parameter logic [31:0] OFFER_FEATURES = 32'h00ef_ffff,
  parameter logic [15:0] QUEUE_PAIRS    = 16'h0004,
  parameter logic [47:0] ADDR_DEFAULT   = 48'h0200_0000_0001,
  // Arbitrary neutral device type value
  parameter logic [31:0] DEVICE_TYPE    = 32'h0000_00a5
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Link state from the network side, asynchronous
  input  wire logic        link_up_i,
  input  wire logic        announce_req_i,
  // Queue and link status
  output logic      [15:0] active_pairs_o,
  output logic      [15:0] ctrl_queue_index_o,
  output logic             ctrl_queue_valid_o,
  output logic             link_up_o
);
  // ==========================================================
  // Offered features and queue-pair limit
  // ==========================================================
  logic [15:0] qp_limit;
  logic [31:0] offer_mask;
  nfc_if       fi ();

  // Limit clamped into the legal range whether or not multiqueue is offered
  assign qp_limit = (QUEUE_PAIRS < nfc_pkg::QP_MIN) ? nfc_pkg::QP_MIN :
                    (QUEUE_PAIRS > nfc_pkg::QP_MAX) ? nfc_pkg::QP_MAX :
                    QUEUE_PAIRS;

  always_comb begin
    offer_mask = OFFER_FEATURES;
    // Positions 3, 4 and 20 are undefined and never offered
    offer_mask[3]  = 1'b0;
    offer_mask[4]  = 1'b0;
    offer_mask[20] = 1'b0;
    offer_mask[31:24] = 8'h00;
    // Station address is a device capability, always worth offering
    offer_mask[nfc_pkg::FB_STATION_ADDR] = 1'b1;
  end

  assign fi.offered = offer_mask;

  nfc_feat_filter nfc_feat_filter_i (
    .f (fi.filter)
  );

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [1:0] link_sync_r;
  logic [1:0] ann_sync_r;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      link_sync_r <= 2'h0;
      ann_sync_r  <= 2'h0;
    end else begin
      link_sync_r <= {link_sync_r[0], link_up_i};
      ann_sync_r  <= {ann_sync_r[0], announce_req_i};
    end
  end

  // ==========================================================
  // Bus handshake: one wait cycle, answer on the second edge
  // ==========================================================
  logic req;
  logic ack_r;
  logic acc;
  logic wr_acc;
  assign req    = avs_read_i | avs_write_i;
  assign acc    = req & ack_r;
  assign wr_acc = avs_write_i & ack_r;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & !ack_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(req & !ack_r);
    end
  end

  // ==========================================================
  // Writable registers
  // ==========================================================
  logic [31:0] request_r;
  logic [31:0] active_r;
  logic [2:0]  ctl_r;
  logic [47:0] addr_r;
  logic [15:0] pairs_r;
  logic [15:0] pairs_nxt;
  logic        ann_r;
  logic        live_wr;

  assign fi.requested = request_r;
  assign live_wr = wr_acc;

  // Driver proposal; the accepted set is latched every cycle except the one that writes the proposal
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      request_r <= nfc_pkg::ZERO_WORD;
      active_r  <= nfc_pkg::ZERO_WORD;
    end else if (live_wr && avs_address_i == nfc_pkg::A_FEAT_ACCEPT) begin
      request_r <= avs_writedata_i;
    end else begin
      active_r  <= fi.accepted;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctl_r <= 3'h0;
    end else if (live_wr && avs_address_i == nfc_pkg::A_CONTROL) begin
      ctl_r <= avs_writedata_i[2:0];
    end
  end

  // Address writable only in legacy mode
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      addr_r <= ADDR_DEFAULT;
    end else if (live_wr && ctl_r[nfc_pkg::CTL_LEGACY]) begin
      if (avs_address_i == nfc_pkg::A_ADDR_LO) begin
        for (int i = 0; i < 4; i++) begin
          if (avs_byteenable_i[i]) begin
            addr_r[i*8 +: 8] <= avs_writedata_i[i*8 +: 8];
          end
        end
      end else if (avs_address_i == nfc_pkg::A_ADDR_HI) begin
        for (int i = 0; i < 2; i++) begin
          if (avs_byteenable_i[i]) begin
            addr_r[32 + i*8 +: 8] <= avs_writedata_i[i*8 +: 8];
          end
        end
      end
    end
  end

  // Pairs-set command: clamp to the limit; one pair by default
  always_comb begin
    pairs_nxt = avs_writedata_i[15:0];
    if (pairs_nxt < nfc_pkg::QP_MIN) begin
      pairs_nxt = nfc_pkg::QP_MIN;
    end
    if (pairs_nxt > qp_limit) begin
      pairs_nxt = qp_limit;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pairs_r <= nfc_pkg::QP_MIN;
    end else if (!active_r[nfc_pkg::FB_MULTI_QUEUE]) begin
      pairs_r <= nfc_pkg::QP_MIN;
    end else if (live_wr && avs_address_i == nfc_pkg::A_PAIRS_SET) begin
      pairs_r <= pairs_nxt;
    end
  end

  // Announce request is sticky; a new request beats the acknowledge
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ann_r <= 1'b0;
    end else if (ann_sync_r[1] && active_r[nfc_pkg::FB_ANNOUNCE]) begin
      ann_r <= 1'b1;
    end else if (live_wr && avs_address_i == nfc_pkg::A_CONTROL &&
                 avs_writedata_i[nfc_pkg::CTL_ANN_ACK]) begin
      ann_r <= 1'b0;
    end
  end

  // ==========================================================
  // Status word, byte order and read mux
  // ==========================================================
  logic [15:0] stat_word;
  logic [15:0] qp_word;
  logic        swap;
  logic [31:0] rd_nxt;
  logic [15:0] pairs_now;
  logic [15:0] n_pairs;
  logic [16:0] ctrl_idx;

  always_comb begin
    stat_word = 16'h0000;
    if (link_sync_r[1]) begin
      stat_word = stat_word | nfc_pkg::STAT_LINK_UP;
    end
    if (ann_r) begin
      stat_word = stat_word | nfc_pkg::STAT_ANNOUNCE;
    end
    // Status only present with the status feature
    if (!active_r[nfc_pkg::FB_STATUS_FIELD]) begin
      stat_word = 16'h0000;
    end
    // Limit only present when multiqueue offered
    qp_word = offer_mask[nfc_pkg::FB_MULTI_QUEUE] ? qp_limit : 16'h0000;
  end

  // Legacy big-endian guest swaps the two bytes within each 16-bit field of the status and limit word
  assign swap = ctl_r[nfc_pkg::CTL_LEGACY] & ctl_r[nfc_pkg::CTL_BIG_END];

  // Map reads skip the output flops, which lag a feature change
  assign pairs_now = active_r[nfc_pkg::FB_MULTI_QUEUE] ? pairs_r
                                                       : nfc_pkg::QP_MIN;

  always_comb begin
    case (avs_address_i)
      nfc_pkg::A_FEAT_OFFER:  rd_nxt = offer_mask;
      nfc_pkg::A_FEAT_ACCEPT: rd_nxt = request_r;
      nfc_pkg::A_FEAT_ACTIVE: rd_nxt = active_r;
      nfc_pkg::A_ADDR_LO:     rd_nxt = addr_r[31:0];
      nfc_pkg::A_ADDR_HI:     rd_nxt = {16'h0000, addr_r[47:32]};
      nfc_pkg::A_STATUS_QP: begin
        if (swap) begin
          rd_nxt = {qp_word[7:0], qp_word[15:8],
                    stat_word[7:0], stat_word[15:8]};
        end else begin
          rd_nxt = {qp_word, stat_word};
        end
      end
      nfc_pkg::A_CONTROL:     rd_nxt = {29'h0, ctl_r};
      nfc_pkg::A_QUEUE_MAP:   rd_nxt = {ctrl_idx[15:0], pairs_now};
      nfc_pkg::A_PAIRS_SET:   rd_nxt = {16'h0000, pairs_r};
      nfc_pkg::A_DEVICE_ID:   rd_nxt = DEVICE_TYPE;
      default:                rd_nxt = nfc_pkg::UNMAP_WORD;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= nfc_pkg::ZERO_WORD;
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // ==========================================================
  // Queue map outputs
  // ==========================================================
  assign n_pairs  = active_r[nfc_pkg::FB_MULTI_QUEUE] ? qp_limit
                                                      : nfc_pkg::QP_MIN;
  // Control queue follows the last transmit queue of the pair limit, not of the pairs set
  assign ctrl_idx = {n_pairs, 1'b0};

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      active_pairs_o     <= nfc_pkg::QP_MIN;
      ctrl_queue_index_o <= 16'h0000;
      ctrl_queue_valid_o <= 1'b0;
      link_up_o          <= 1'b0;
    end else begin
      active_pairs_o     <= pairs_r;
      ctrl_queue_index_o <= ctrl_idx[15:0];
      ctrl_queue_valid_o <= active_r[nfc_pkg::FB_CTRL_QUEUE];
      link_up_o          <= link_sync_r[1];
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_wait_one: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    $rose(req) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest not one cycle");
  a_ctrl_gate: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    ctrl_queue_valid_o |-> $past(active_r[nfc_pkg::FB_CTRL_QUEUE]))
    else $error("control queue without feature");
  a_dep_csum: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    active_r[nfc_pkg::FB_DRV_TCP4] |-> active_r[nfc_pkg::FB_DRV_CSUM])
    else $error("driver tcp4 without checksum");
  a_dep_ctrl: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    active_r[nfc_pkg::FB_MULTI_QUEUE] |-> active_r[nfc_pkg::FB_CTRL_QUEUE])
    else $error("multiqueue without control queue");
  a_qp_range: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    qp_limit >= nfc_pkg::QP_MIN && qp_limit <= nfc_pkg::QP_MAX)
    else $error("queue pair limit out of range");
  a_pairs_default: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    !active_r[nfc_pkg::FB_MULTI_QUEUE] |=> pairs_r == nfc_pkg::QP_MIN)
    else $error("extra pairs without multiqueue");
  a_pairs_limit: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    pairs_r >= nfc_pkg::QP_MIN && pairs_r <= qp_limit)
    else $error("pair count outside limit");
  a_link_follow: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    $rose(link_up_i) ##1 link_up_i[*3] |-> link_up_o)
    else $error("link flag lags input");
  a_addr_locked: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    !ctl_r[nfc_pkg::CTL_LEGACY] |=> $stable(addr_r))
    else $error("address changed outside legacy");
  a_ctrl_index: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    !$past(active_r[nfc_pkg::FB_MULTI_QUEUE]) && $past(resetn_i)
    |-> ctrl_queue_index_o == 16'h0002)
    else $error("control index wrong for one pair");
  c_read: cover property (@(posedge ref_clk_i) acc && avs_read_i);
  c_accept: cover property (@(posedge ref_clk_i) active_r[22]);
  c_legacy_wr: cover property (@(posedge ref_clk_i) live_wr && ctl_r[0]);
  c_announce: cover property (@(posedge ref_clk_i) $rose(ann_r));
  c_pairs_set: cover property (@(posedge ref_clk_i)
    live_wr && avs_address_i == nfc_pkg::A_PAIRS_SET);
endmodule

// [logic/nfc_pkg.sv]
// Constants for the network feature and configuration register bank
package nfc_pkg;
  // Feature bit positions
  localparam int FB_DEV_CSUM      = 0;
  localparam int FB_DRV_CSUM      = 1;
  localparam int FB_CTRL_OFFLOAD  = 2;
  localparam int FB_STATION_ADDR  = 5;
  localparam int FB_LEGACY_SEG    = 6;
  localparam int FB_DRV_TCP4      = 7;
  localparam int FB_DRV_TCP6      = 8;
  localparam int FB_DRV_CONG      = 9;
  localparam int FB_DRV_UDP       = 10;
  localparam int FB_DEV_TCP4      = 11;
  localparam int FB_DEV_TCP6      = 12;
  localparam int FB_DEV_CONG      = 13;
  localparam int FB_DEV_UDP       = 14;
  localparam int FB_MERGED_RX     = 15;
  localparam int FB_STATUS_FIELD  = 16;
  localparam int FB_CTRL_QUEUE    = 17;
  localparam int FB_CTRL_RX_MODE  = 18;
  localparam int FB_CTRL_VLAN     = 19;
  localparam int FB_ANNOUNCE      = 21;
  localparam int FB_MULTI_QUEUE   = 22;
  localparam int FB_CTRL_ADDR_SET = 23;

  // Status word masks
  localparam logic [15:0] STAT_LINK_UP  = 16'h0001;
  localparam logic [15:0] STAT_ANNOUNCE = 16'h0002;

  // Queue-pair limit bounds
  localparam logic [15:0] QP_MIN = 16'h0001;
  localparam logic [15:0] QP_MAX = 16'h8000;

  // Register byte addresses
  localparam logic [5:0] A_FEAT_OFFER  = 6'h00;
  localparam logic [5:0] A_FEAT_ACCEPT = 6'h04;
  localparam logic [5:0] A_FEAT_ACTIVE = 6'h08;
  localparam logic [5:0] A_ADDR_LO     = 6'h0c;
  localparam logic [5:0] A_ADDR_HI     = 6'h10;
  localparam logic [5:0] A_STATUS_QP   = 6'h14;
  localparam logic [5:0] A_CONTROL     = 6'h18;
  localparam logic [5:0] A_QUEUE_MAP   = 6'h1c;
  localparam logic [5:0] A_PAIRS_SET   = 6'h20;
  localparam logic [5:0] A_DEVICE_ID   = 6'h24;

  // Control register fields
  localparam int CTL_LEGACY   = 0;
  localparam int CTL_BIG_END  = 1;
  localparam int CTL_ANN_ACK  = 2;

  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [31:0] UNMAP_WORD  = 32'hdead_0000;
endpackage

// [logic/nfc_if.sv]
// Carrier between register bank and feature-dependency filter
`timescale 1ns/1ps
interface nfc_if;
  logic [31:0] requested;
  logic [31:0] offered;
  logic [31:0] accepted;
  modport bank   (output requested, output offered, input accepted);
  modport filter (input requested, input offered, output accepted);
endinterface

// [logic/nfc_feat_filter.sv]
// Feature dependency filter for the accepted feature set
`timescale 1ns/1ps
module nfc_feat_filter (
  nfc_if.filter f
);
  logic [31:0] req;
  logic        csum_dev;
  logic        csum_drv;
  logic        ctrl_q;
  logic        drv_tso;
  logic        dev_tso;

  always_comb begin
    req      = f.requested & f.offered;
    csum_dev = req[nfc_pkg::FB_DEV_CSUM];
    csum_drv = req[nfc_pkg::FB_DRV_CSUM];
    ctrl_q   = req[nfc_pkg::FB_CTRL_QUEUE];
    drv_tso  = 1'b0;
    dev_tso  = 1'b0;
    // Drop any bit whose prerequisite is missing
    if (!csum_drv) begin
      req[nfc_pkg::FB_DRV_TCP4] = 1'b0;
      req[nfc_pkg::FB_DRV_TCP6] = 1'b0;
      req[nfc_pkg::FB_DRV_UDP]  = 1'b0;
    end
    if (!csum_dev) begin
      req[nfc_pkg::FB_DEV_TCP4] = 1'b0;
      req[nfc_pkg::FB_DEV_TCP6] = 1'b0;
      req[nfc_pkg::FB_DEV_UDP]  = 1'b0;
    end
    drv_tso = req[nfc_pkg::FB_DRV_TCP4] | req[nfc_pkg::FB_DRV_TCP6];
    dev_tso = req[nfc_pkg::FB_DEV_TCP4] | req[nfc_pkg::FB_DEV_TCP6];
    if (!drv_tso) begin
      req[nfc_pkg::FB_DRV_CONG] = 1'b0;
    end
    if (!dev_tso) begin
      req[nfc_pkg::FB_DEV_CONG] = 1'b0;
    end
    if (!ctrl_q) begin
      req[nfc_pkg::FB_CTRL_RX_MODE]  = 1'b0;
      req[nfc_pkg::FB_CTRL_VLAN]     = 1'b0;
      req[nfc_pkg::FB_ANNOUNCE]      = 1'b0;
      req[nfc_pkg::FB_MULTI_QUEUE]   = 1'b0;
      req[nfc_pkg::FB_CTRL_ADDR_SET] = 1'b0;
      req[nfc_pkg::FB_CTRL_OFFLOAD]  = 1'b0;
    end
  end

  assign f.accepted = req;
endmodule

// [testbench/nfc_drv_model.sv]
// Guest driver model: Avalon-MM master for the feature register bank
`timescale 1ns/1ps
module nfc_drv_model (
  // Clock
  input  wire logic        clk_i,
  // Avalon-MM master
  output logic      [5:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  output logic      [3:0]  byteenable_o,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i
);
  initial begin
    address_o    = 6'h00;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = 32'h0000_0000;
    byteenable_o = 4'hf;
  end

  // ==========================================================
  // Bus cycle
  // Held until waitrequest seen low; data inverted once released
  task automatic access(input logic [5:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    address_o   <= a;
    writedata_o <= d;
    read_o      <= !w;
    write_o     <= w;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o      <= 1'b0;
    write_o     <= 1'b0;
    writedata_o <= ~d;
  endtask

  // ==========================================================
  // Driver duties
  task automatic adopt_address(output logic [47:0] addr);
    logic [31:0] lo;
    logic [31:0] hi;
    access(nfc_pkg::A_ADDR_LO, 1'b0, 32'h0000_0000, lo);
    access(nfc_pkg::A_ADDR_HI, 1'b0, 32'h0000_0000, hi);
    addr = {hi[15:0], lo};
  endtask

  // Link taken from status bit 0, assumed up without the status feature
  task automatic read_link(input logic status_neg, output logic up);
    logic [31:0] q;
    up = 1'b1;
    if (status_neg) begin
      access(nfc_pkg::A_STATUS_QP, 1'b0, 32'h0000_0000, q);
      up = q[0];
    end
  endtask

  task automatic find_queues(output logic [15:0] n, output logic [15:0] c);
    logic [31:0] q;
    access(nfc_pkg::A_QUEUE_MAP, 1'b0, 32'h0000_0000, q);
    n = q[15:0];
    c = q[31:16];
  endtask

  task automatic accept_minimal();
    logic [31:0] q;
    access(nfc_pkg::A_FEAT_ACCEPT, 1'b1, 32'h0000_0020, q);
  endtask
endmodule

// [testbench/nfc_tb_top.sv]
// Self-checking testbench for the feature and configuration bank
`timescale 1ns/1ps
module nfc_tb_top;
  // Offer with forbidden bits set and bit 5 clear on purpose
  localparam logic [31:0] OFFER_P   = 32'hffff_ffdf;
  localparam logic [31:0] OFFER_EXP = 32'h00ef_ffe7;
  localparam logic [15:0] QP_P      = 16'h0004;
  localparam logic [47:0] ADDR_P    = 48'h0200_0000_0001;
  // Arbitrary device type value
  localparam logic [31:0] DEV_P     = 32'h0000_005c;
  localparam int          LIMIT     = 4000;

  logic        ref_clk;
  logic        resetn;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        link_up;
  logic        announce_req;
  logic [15:0] active_pairs;
  logic [15:0] ctrl_idx;
  logic        ctrl_valid;
  logic        link_state;
  int          n_errors;
  int          checks;
  int          cycles;

  nfc_top #(.OFFER_FEATURES(OFFER_P), .QUEUE_PAIRS(QP_P),
            .ADDR_DEFAULT(ADDR_P), .DEVICE_TYPE(DEV_P)) nfc_top_i (
    .ref_clk_i(ref_clk), .resetn_i(resetn),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .link_up_i(link_up),
    .announce_req_i(announce_req), .active_pairs_o(active_pairs),
    .ctrl_queue_index_o(ctrl_idx), .ctrl_queue_valid_o(ctrl_valid),
    .link_up_o(link_state));

  nfc_drv_model nfc_drv_model_i (
    .clk_i(ref_clk), .address_o(avs_address), .read_o(avs_read),
    .write_o(avs_write), .writedata_o(avs_writedata),
    .byteenable_o(avs_byteenable), .readdata_i(avs_readdata),
    .waitrequest_i(avs_waitrequest));

  always #12.5 ref_clk = ~ref_clk;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
               got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    nfc_drv_model_i.access(a, 1'b1, d, q);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                     input string what);
    logic [31:0] q;
    nfc_drv_model_i.access(a, 1'b0, 32'h0000_0000, q);
    chk(q, e, what);
  endtask

  // Dependency pruning worked out independently of the design
  function automatic logic [31:0] prune(input logic [31:0] r);
    logic [31:0] a;
    a = r;
    if (!a[1]) a &= ~32'h0000_0580;
    if (!a[0]) a &= ~32'h0000_5800;
    if (!(a[7] | a[8])) a[9] = 1'b0;
    if (!(a[11] | a[12])) a[13] = 1'b0;
    if (!a[17]) a &= ~32'h00ec_0004;
    return a;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    logic [47:0] a;
    chk({16'h0000, active_pairs}, 32'h0000_0001, "pairs");
    chk({31'h0, ctrl_valid}, 32'h0000_0000, "ctrl valid");
    rdc(nfc_pkg::A_FEAT_OFFER, OFFER_EXP, "offer");
    rdc(nfc_pkg::A_DEVICE_ID, DEV_P, "device type");
    rdc(6'h28, nfc_pkg::UNMAP_WORD, "unmapped");
    wr(nfc_pkg::A_FEAT_OFFER, 32'h0000_0000);
    wr(nfc_pkg::A_STATUS_QP, 32'hffff_ffff);
    rdc(nfc_pkg::A_FEAT_OFFER, OFFER_EXP, "offer kept");
    rdc(nfc_pkg::A_STATUS_QP, {QP_P, 16'h0000}, "limit");
    nfc_drv_model_i.adopt_address(a);
    chk(a[31:0], ADDR_P[31:0], "addr lo");
    chk({16'h0000, a[47:32]}, {16'h0000, ADDR_P[47:32]}, "addr hi");
    $display("test_reset done");
  endtask

  task automatic test_negotiate();
    logic [31:0] reqs [4];
    logic [31:0] e;
    reqs = '{32'hffff_fffc, 32'h00ed_ffe7, 32'h0000_0203, 32'h0000_2801};
    foreach (reqs[i]) begin
      e = prune(reqs[i] & OFFER_EXP);
      wr(nfc_pkg::A_FEAT_ACCEPT, reqs[i]);
      rdc(nfc_pkg::A_FEAT_ACTIVE, e, "accepted");
      chk({31'h0, ctrl_valid}, {31'h0, e[17]}, "ctrl valid");
    end
    $display("test_negotiate done");
  endtask

  task automatic test_pairs();
    logic [15:0] req [4];
    logic [15:0] e [4];
    logic [15:0] np;
    logic [15:0] cq;
    req = '{16'h0003, 16'h0000, 16'h0009, 16'h0004};
    e = '{16'h0003, 16'h0001, 16'h0004, 16'h0004};
    wr(nfc_pkg::A_FEAT_ACCEPT, OFFER_EXP);
    rdc(nfc_pkg::A_QUEUE_MAP, {16'h0008, 16'h0001}, "map");
    nfc_drv_model_i.find_queues(np, cq);
    chk({cq, np}, {16'h0008, 16'h0001}, "discover");
    foreach (req[i]) begin
      wr(nfc_pkg::A_PAIRS_SET, {16'h0000, req[i]});
      rdc(nfc_pkg::A_QUEUE_MAP, {16'h0008, e[i]}, "map");
      chk({16'h0000, active_pairs}, {16'h0000, e[i]}, "pairs");
      chk({16'h0000, ctrl_idx}, 32'h0000_0008, "ctrl index");
    end
    wr(nfc_pkg::A_FEAT_ACCEPT, 32'h0002_0020);
    rdc(nfc_pkg::A_QUEUE_MAP, {16'h0002, 16'h0001}, "one pair");
    $display("test_pairs done");
  endtask

  task automatic test_status();
    int n;
    logic up;
    wr(nfc_pkg::A_FEAT_ACCEPT, OFFER_EXP);
    link_up <= 1'b1;
    n = 0;
    while (link_state !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, link_state}, 32'h0000_0001, "link");
    rdc(nfc_pkg::A_STATUS_QP, {QP_P, 16'h0001}, "status");
    nfc_drv_model_i.read_link(1'b1, up);
    chk({31'h0, up}, 32'h0000_0001, "link read");
    announce_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    announce_req <= 1'b0;
    rdc(nfc_pkg::A_STATUS_QP, {QP_P, 16'h0003}, "announce");
    wr(nfc_pkg::A_CONTROL, 32'h0000_0004);
    rdc(nfc_pkg::A_STATUS_QP, {QP_P, 16'h0001}, "ack");
    wr(nfc_pkg::A_FEAT_ACCEPT, OFFER_EXP & ~32'h0001_0000);
    rdc(nfc_pkg::A_STATUS_QP, {QP_P, 16'h0000}, "no status");
    $display("test_status done");
  endtask

  task automatic test_legacy();
    wr(nfc_pkg::A_ADDR_LO, 32'h1234_5678);
    rdc(nfc_pkg::A_ADDR_LO, ADDR_P[31:0], "addr locked");
    wr(nfc_pkg::A_CONTROL, 32'h0000_0001);
    wr(nfc_pkg::A_ADDR_LO, 32'h1234_5678);
    wr(nfc_pkg::A_ADDR_HI, 32'h0000_abcd);
    rdc(nfc_pkg::A_ADDR_LO, 32'h1234_5678, "addr lo");
    rdc(nfc_pkg::A_ADDR_HI, 32'h0000_abcd, "addr hi");
    wr(nfc_pkg::A_FEAT_ACCEPT, OFFER_EXP);
    wr(nfc_pkg::A_CONTROL, 32'h0000_0003);
    rdc(nfc_pkg::A_STATUS_QP, 32'h0400_0100, "guest order");
    wr(nfc_pkg::A_CONTROL, 32'h0000_0000);
    $display("test_legacy done");
  endtask

  task automatic test_minimal();
    nfc_drv_model_i.accept_minimal();
    rdc(nfc_pkg::A_FEAT_ACTIVE, 32'h0000_0020, "minimal");
    chk({31'h0, ctrl_valid}, 32'h0000_0000, "no ctrl");
    chk({16'h0000, active_pairs}, 32'h0000_0001, "pairs");
    $display("test_minimal done");
  endtask

  initial begin
    ref_clk      = 1'b0;
    resetn       = 1'b0;
    link_up      = 1'b0;
    announce_req = 1'b0;
    n_errors     = 0;
    checks       = 0;
    cycles       = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    test_reset();
    test_negotiate();
    test_pairs();
    test_status();
    test_legacy();
    test_minimal();
    print_verdict();
  end
endmodule
